/* hdl/mcs_regs.sv */
`timescale 1ns/1ps
// Summary of operation
// - Noise register holds last AGC noise, top zero.
// - Count symbol ticks waited until sync detect.
// - Capture last frame address into two bytes.
// - Transmit-on-wake requests transmission after each wake.
// - Auto reply swaps receive and transmit after success.
// - Two-bit field selects modulation coding.
// - Two-bit field selects error correction rate.
// - Preamble lasts (setting plus seven) times two.
// - Sync pattern from four bytes, MSB lowest.
// - Polynomial from byte pair, high resets zero.
// - Address width select: set 16-bit, clear 8-bit.
module mcs_regs #(
	parameter logic [7:0] CRC_LO_RESET = 8'h00
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire mcs_pkg::mcs_req_s req,
	output logic [mcs_pkg::MCS_DW-1:0] rd_data,
	output logic rd_valid,
	output mcs_pkg::mcs_cfg_s cfg,
	output logic [mcs_pkg::MCS_PRE_W-1:0] preamble_symbols,
	input wire logic address_width_select,
	input wire logic agc_active,
	input wire logic noise_valid,
	input wire logic [mcs_pkg::MCS_NOISE_W-1:0] noise_level_indicator,
	input wire logic symbol_tick,
	input wire logic rx_waiting,
	input wire logic sync_detect,
	input wire logic frame_addr_valid,
	input wire logic [15:0] last_frame_address,
	input wire logic wake_event,
	input wire logic rx_success,
	input wire logic tx_success,
	input wire logic preamble_start,
	output logic preamble_active,
	output logic tx_request,
	output logic rx_request
);
	import mcs_pkg::*;

	typedef enum {MCS_PRE_IDLE, MCS_PRE_RUN} mcs_pre_e;

	logic [MCS_NOISE_W-1:0] noise_reg, noise_next;
	logic [15:0] faddr_reg, faddr_next;
	logic [MCS_DW-1:0] feat_reg, feat_next;
	logic [MCS_DW-1:0] pre_len_reg, pre_len_next;
	logic [31:0] sync_reg, sync_next;
	logic [15:0] crc_reg, crc_next;
	logic [MCS_DW-1:0] rd_data_reg, rd_data_next;
	logic rd_valid_reg, rd_valid_next;
	logic [MCS_WAIT_W-1:0] wait_count;
	logic tx_req_reg, tx_req_next;
	logic rx_req_reg, rx_req_next;
	mcs_pre_e pre_state_reg, pre_state_next;
	logic [MCS_PRE_W-1:0] pre_cnt_reg, pre_cnt_next;

	mcs_wait_counter #(
		.WIDTH(MCS_WAIT_W)
	) u_wait (
		.mclk(mclk),
		.rst_n(rst_n),
		.symbol_tick(symbol_tick),
		.rx_waiting(rx_waiting),
		.sync_detect(sync_detect),
		.wait_count(wait_count)
	);

	// Status capture and software writes share one next-state process.
	always_comb begin
		noise_next = noise_reg;
		faddr_next = faddr_reg;
		feat_next = feat_reg;
		pre_len_next = pre_len_reg;
		sync_next = sync_reg;
		crc_next = crc_reg;
		// Outside automatic gain the noise figure is meaningless, so keep the last one.
		if (noise_valid && agc_active) begin
			noise_next = noise_level_indicator;
		end
		if (frame_addr_valid) begin
			if (address_width_select) begin
				faddr_next = last_frame_address;
			end else begin
				faddr_next = {8'h00, last_frame_address[7:0]};
			end
		end
		if (req.wr) begin
			case (req.addr)
				ADDR_FEATURES: feat_next = req.wdata & FEAT_WR_MASK;
				ADDR_PREAMBLE: pre_len_next = req.wdata;
				ADDR_SYNC3: sync_next[31:24] = req.wdata;
				ADDR_SYNC2: sync_next[23:16] = req.wdata;
				ADDR_SYNC1: sync_next[15:8] = req.wdata;
				ADDR_SYNC0: sync_next[7:0] = req.wdata;
				ADDR_CRC_HI: crc_next[15:8] = req.wdata;
				ADDR_CRC_LO: crc_next[7:0] = req.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			noise_reg <= '0;
			faddr_reg <= '0;
			feat_reg <= RST_FEATURES;
			pre_len_reg <= RST_PREAMBLE;
			sync_reg <= {RST_SYNC3, RST_SYNC2, RST_SYNC1, RST_SYNC0};
			crc_reg <= {RST_CRC_HI, CRC_LO_RESET};
		end else begin
			noise_reg <= noise_next;
			faddr_reg <= faddr_next;
			feat_reg <= feat_next;
			pre_len_reg <= pre_len_next;
			sync_reg <= sync_next;
			crc_reg <= crc_next;
		end
	end

	// Read data is registered; the answer appears one cycle after the strobe.
	always_comb begin
		rd_valid_next = req.rd;
		rd_data_next = rd_data_reg;
		if (req.rd) begin
			case (req.addr)
				ADDR_NOISE: rd_data_next = {2'b00, noise_reg};
				ADDR_WAIT_HI: rd_data_next = wait_count[15:8];
				ADDR_WAIT_LO: rd_data_next = wait_count[7:0];
				ADDR_FADDR_HI: rd_data_next = faddr_reg[15:8];
				ADDR_FADDR_LO: rd_data_next = faddr_reg[7:0];
				ADDR_FEATURES: rd_data_next = feat_reg;
				ADDR_PREAMBLE: rd_data_next = pre_len_reg;
				ADDR_SYNC3: rd_data_next = sync_reg[31:24];
				ADDR_SYNC2: rd_data_next = sync_reg[23:16];
				ADDR_SYNC1: rd_data_next = sync_reg[15:8];
				ADDR_SYNC0: rd_data_next = sync_reg[7:0];
				ADDR_CRC_HI: rd_data_next = crc_reg[15:8];
				ADDR_CRC_LO: rd_data_next = crc_reg[7:0];
				default: rd_data_next = RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rd_data_reg <= RST_ZERO;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;

	always_comb begin
		cfg.transmit_on_wake = feat_reg[FEAT_AUTO_TX];
		cfg.auto_reply_enable = feat_reg[FEAT_AUTO_REPLY];
		cfg.modulation_select = mcs_mod_e'(feat_reg[FEAT_MOD_LSB +: 2]);
		cfg.error_correction_rate = mcs_fec_e'(feat_reg[FEAT_FEC_LSB +: 2]);
		cfg.preamble_length_setting = pre_len_reg;
		cfg.frame_sync_pattern = sync_reg;
		cfg.check_polynomial = crc_reg;
	end

	assign preamble_symbols = ({2'b00, pre_len_reg} + PRE_EXTRA) << PRE_SHIFT;

	// A reply request wins over nothing else: both can fire when events coincide.
	always_comb begin
		tx_req_next = (wake_event && cfg.transmit_on_wake)
			|| (rx_success && cfg.auto_reply_enable);
		rx_req_next = tx_success && cfg.auto_reply_enable;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tx_req_reg <= 1'b0;
			rx_req_reg <= 1'b0;
		end else begin
			tx_req_reg <= tx_req_next;
			rx_req_reg <= rx_req_next;
		end
	end

	assign tx_request = tx_req_reg;
	assign rx_request = rx_req_reg;

	// The length is sampled live, so software must not change it mid-preamble.
	always_comb begin
		pre_state_next = pre_state_reg;
		pre_cnt_next = pre_cnt_reg;
		case (pre_state_reg)
			MCS_PRE_IDLE: begin
				if (preamble_start) begin
					pre_state_next = MCS_PRE_RUN;
					pre_cnt_next = '0;
				end
			end
			MCS_PRE_RUN: begin
				if (symbol_tick) begin
					pre_cnt_next = pre_cnt_reg + 1'b1;
					if (pre_cnt_next == preamble_symbols) begin
						pre_state_next = MCS_PRE_IDLE;
					end
				end
			end
			default: pre_state_next = MCS_PRE_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pre_state_reg <= MCS_PRE_IDLE;
			pre_cnt_reg <= '0;
		end else begin
			pre_state_reg <= pre_state_next;
			pre_cnt_reg <= pre_cnt_next;
		end
	end

	assign preamble_active = (pre_state_reg == MCS_PRE_RUN);

	noise_capture_a: assert property (@(posedge mclk) disable iff (!rst_n)
		noise_valid && agc_active ##1 req.rd && req.addr == ADDR_NOISE
		|=> rd_data == {2'b00, $past(noise_level_indicator, 2)})
		else $error("noise level not reported");
	noise_top_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
		rd_valid && $past(req.addr) == ADDR_NOISE |-> rd_data[7:6] == 2'b00)
		else $error("noise top bits not zero");
	short_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
		frame_addr_valid && !address_width_select
		|=> faddr_reg == {8'h00, $past(last_frame_address[7:0])})
		else $error("8-bit frame address capture wrong");
	wake_tx_a: assert property (@(posedge mclk) disable iff (!rst_n)
		wake_event && cfg.transmit_on_wake |=> tx_request ##1 !tx_request
		|| $past(wake_event) || $past(rx_success))
		else $error("no transmit after wake");
	reply_swap_a: assert property (@(posedge mclk) disable iff (!rst_n)
		tx_success && cfg.auto_reply_enable |=> rx_request)
		else $error("no receive request after transmit");
	no_reply_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!cfg.auto_reply_enable && !cfg.transmit_on_wake |=> !tx_request)
		else $error("transmit request without enable");
	mod_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.wr && req.addr == ADDR_FEATURES
		|=> cfg.modulation_select == mcs_mod_e'($past(req.wdata[3:2]))
		&& cfg.error_correction_rate == mcs_fec_e'($past(req.wdata[1:0])))
		else $error("coding fields not taken from write");
	preamble_len_a: assert property (@(posedge mclk) disable iff (!rst_n)
		pre_state_reg == MCS_PRE_RUN && symbol_tick
		&& pre_cnt_reg + 1'b1 == preamble_symbols |=> !preamble_active)
		else $error("preamble did not end on count");
	preamble_sum_a: assert property (@(posedge mclk) disable iff (!rst_n)
		preamble_symbols == 2 * (pre_len_reg + 7))
		else $error("preamble length formula wrong");
	sync_order_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.wr && req.addr == ADDR_SYNC3
		|=> cfg.frame_sync_pattern[31:24] == $past(req.wdata))
		else $error("sync top byte not from lowest address");
	crc_reset_a: assert property (@(posedge mclk)
		!rst_n |=> cfg.check_polynomial[15:8] == 8'h00)
		else $error("polynomial high byte not reset");
	ro_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.wr && req.addr == ADDR_FADDR_LO && !frame_addr_valid
		|=> $stable(faddr_reg))
		else $error("read-only register was written");
	rsvd_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.rd && req.addr == 6'h28 |=> rd_data == 8'h00)
		else $error("reserved read not zero");

	pre_run_c: cover property (@(posedge mclk) disable iff (!rst_n)
		$fell(preamble_active));
	reply_c: cover property (@(posedge mclk) disable iff (!rst_n)
		rx_request);
	wake_c: cover property (@(posedge mclk) disable iff (!rst_n)
		wake_event && cfg.transmit_on_wake);
	wait_rd_c: cover property (@(posedge mclk) disable iff (!rst_n)
		req.rd && req.addr == ADDR_WAIT_LO && wait_count != '0);

endmodule // mcs_regs

/* hdl/mcs_wait_counter.sv */
`timescale 1ns/1ps
module mcs_wait_counter #(
	parameter int WIDTH = mcs_pkg::MCS_WAIT_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic symbol_tick,
	input wire logic rx_waiting,
	input wire logic sync_detect,
	output logic [WIDTH-1:0] wait_count
);
	import mcs_pkg::*;

	logic [WIDTH-1:0] run_reg, run_next;
	logic [WIDTH-1:0] hold_reg, hold_next;

	// The running count saturates so a very long wait never wraps to a small value.
	always_comb begin
		run_next = run_reg;
		hold_next = hold_reg;
		if (sync_detect) begin
			hold_next = run_reg;
			run_next = '0;
		end else if (!rx_waiting) begin
			run_next = '0;
		end else if (symbol_tick && run_reg != {WIDTH{1'b1}}) begin
			run_next = run_reg + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			run_reg <= '0;
			hold_reg <= '0;
		end else begin
			run_reg <= run_next;
			hold_reg <= hold_next;
		end
	end

	assign wait_count = hold_reg;

	wait_capture_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sync_detect |=> wait_count == $past(run_reg))
		else $error("wait count not captured at sync detect");
	wait_count_up_a: assert property (@(posedge mclk) disable iff (!rst_n)
		rx_waiting && !sync_detect && symbol_tick && !(&run_reg)
		|=> run_reg == $past(run_reg) + 1'b1)
		else $error("wait counter missed a symbol tick");

endmodule // mcs_wait_counter

/* pkg/mcs_pkg.sv */
package mcs_pkg;

	localparam int MCS_AW = 6;
	localparam int MCS_DW = 8;
	localparam int MCS_NOISE_W = 6;
	localparam int MCS_WAIT_W = 16;
	localparam int MCS_PRE_W = 10;

	localparam logic [MCS_AW-1:0] ADDR_NOISE = 6'h23;
	localparam logic [MCS_AW-1:0] ADDR_WAIT_HI = 6'h24;
	localparam logic [MCS_AW-1:0] ADDR_WAIT_LO = 6'h25;
	localparam logic [MCS_AW-1:0] ADDR_FADDR_HI = 6'h26;
	localparam logic [MCS_AW-1:0] ADDR_FADDR_LO = 6'h27;
	localparam logic [MCS_AW-1:0] ADDR_FEATURES = 6'h2C;
	localparam logic [MCS_AW-1:0] ADDR_PREAMBLE = 6'h2F;
	localparam logic [MCS_AW-1:0] ADDR_SYNC3 = 6'h32;
	localparam logic [MCS_AW-1:0] ADDR_SYNC2 = 6'h33;
	localparam logic [MCS_AW-1:0] ADDR_SYNC1 = 6'h34;
	localparam logic [MCS_AW-1:0] ADDR_SYNC0 = 6'h35;
	localparam logic [MCS_AW-1:0] ADDR_CRC_HI = 6'h36;
	localparam logic [MCS_AW-1:0] ADDR_CRC_LO = 6'h37;

	localparam logic [MCS_DW-1:0] RST_FEATURES = 8'h00;
	localparam logic [MCS_DW-1:0] RST_PREAMBLE = 8'h27;
	localparam logic [MCS_DW-1:0] RST_SYNC3 = 8'h5E;
	localparam logic [MCS_DW-1:0] RST_SYNC2 = 8'hA6;
	localparam logic [MCS_DW-1:0] RST_SYNC1 = 8'hC1;
	localparam logic [MCS_DW-1:0] RST_SYNC0 = 8'h1D;
	localparam logic [MCS_DW-1:0] RST_CRC_HI = 8'h00;
	localparam logic [MCS_DW-1:0] RST_ZERO = 8'h00;

	localparam int FEAT_AUTO_TX = 7;
	localparam int FEAT_AUTO_REPLY = 6;
	localparam int FEAT_MOD_LSB = 2;
	localparam int FEAT_FEC_LSB = 0;
	localparam logic [MCS_DW-1:0] FEAT_WR_MASK = 8'hCF;

	localparam logic [MCS_PRE_W-1:0] PRE_EXTRA = 10'h007;
	localparam int PRE_SHIFT = 1;

	typedef enum logic [1:0] {
		MCS_MOD_OOK,
		MCS_MOD_OOK_INV,
		MCS_MOD_PPM,
		MCS_MOD_PPM_2B
	} mcs_mod_e;

	typedef enum logic [1:0] {
		MCS_FEC_OFF,
		MCS_FEC_1V33,
		MCS_FEC_1V66,
		MCS_FEC_2V00
	} mcs_fec_e;

	typedef struct packed {
		logic [MCS_AW-1:0] addr;
		logic wr;
		logic rd;
		logic [MCS_DW-1:0] wdata;
	} mcs_req_s;

	typedef struct packed {
		logic transmit_on_wake;
		logic auto_reply_enable;
		mcs_mod_e modulation_select;
		mcs_fec_e error_correction_rate;
		logic [MCS_DW-1:0] preamble_length_setting;
		logic [31:0] frame_sync_pattern;
		logic [15:0] check_polynomial;
	} mcs_cfg_s;

endpackage

/* tb/mcs_host.sv */
`timescale 1ns/1ps
module mcs_host (
	input wire logic mclk,
	input wire logic rd_valid,
	input wire logic [mcs_pkg::MCS_DW-1:0] rd_data,
	output mcs_pkg::mcs_req_s req
);
	import mcs_pkg::*;

	initial req = '0;

	// A request is held for exactly one edge, so no access is taken twice.
	task automatic wr(input logic [MCS_AW-1:0] a, input logic [MCS_DW-1:0] d);
		@(posedge mclk);
		req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge mclk);
		req <= '0;
	endtask

	// The answer is looked at mid-cycle, after its registering edge settled.
	task automatic rd(input logic [MCS_AW-1:0] a, output logic [MCS_DW-1:0] d,
		output logic ok);
		@(posedge mclk);
		req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge mclk);
		req <= '0;
		@(negedge mclk);
		ok = rd_valid;
		d = rd_data;
	endtask
endmodule // mcs_host

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import mcs_pkg::*;

	logic mclk, rst_n, aw, agc, nv, tick, rxw, syn, fav, wake, rxs, txs, pst;
	logic rdv, pact, txr, rxr;
	logic [5:0] nli;
	logic [15:0] fa;
	logic [7:0] rdd;
	logic [9:0] psym;
	mcs_req_s req;
	mcs_cfg_s cfg;
	int mdl [64];
	int num_errors = 0;
	int n_tests = 0;
	int seed, v, n, p, fl [3];

	mcs_host i_host (.mclk(mclk), .rd_valid(rdv), .rd_data(rdd), .req(req));

	mcs_regs i_dut (.mclk(mclk), .rst_n(rst_n), .req(req), .rd_data(rdd),
		.rd_valid(rdv), .cfg(cfg), .preamble_symbols(psym),
		.address_width_select(aw), .agc_active(agc), .noise_valid(nv),
		.noise_level_indicator(nli), .symbol_tick(tick), .rx_waiting(rxw),
		.sync_detect(syn), .frame_addr_valid(fav), .last_frame_address(fa),
		.wake_event(wake), .rx_success(rxs), .tx_success(txs),
		.preamble_start(pst), .preamble_active(pact), .tx_request(txr),
		.rx_request(rxr));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic end_sim;
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string m);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic rdc(input int a);
		logic [7:0] d;
		logic ok;
		i_host.rd(a[5:0], d, ok);
		chk({15'h0000, ok}, 16'h0001, "read valid");
		chk({8'h00, d}, mdl[a][15:0], "read data");
	endtask

	// Only the writable places follow a write; feature bits 5:4 stay zero.
	task automatic wrm(input int a, input int d);
		i_host.wr(a[5:0], d[7:0]);
		if (a == 'h2C)
			mdl[a] = d & 'hCF;
		else if (a == 'h2F || (a >= 'h32 && a <= 'h37))
			mdl[a] = d & 'hFF;
	endtask

	initial begin
		#2000000;
		num_errors++;
		end_sim();
	end

	initial begin
		seed = 83;
		{rst_n, aw, agc, nv, tick, rxw, syn, fav, wake, rxs, txs, pst} = '0;
		nli = '0;
		fa = '0;
		fl = '{'h00, 'h80, 'h40};
		foreach (mdl[i]) mdl[i] = 0;
		mdl['h2F] = RST_PREAMBLE;
		mdl['h32] = RST_SYNC3;
		mdl['h33] = RST_SYNC2;
		mdl['h34] = RST_SYNC1;
		mdl['h35] = RST_SYNC0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		for (int a = 0; a < 64; a++)
			if (a < 'h23 || a > 'h27) rdc(a);
		// Noise is taken only while gain control runs.
		for (int g = 1; g >= 0; g--) begin
			v = $random(seed);
			@(posedge mclk) {agc, nv, nli} <= {g[0], 1'b1, v[5:0]};
			@(posedge mclk) nv <= 1'b0;
			if (g == 1) mdl['h23] = v & 'h3F;
			rdc('h23);
		end
		for (int w = 0; w < 2; w++) begin
			v = $random(seed);
			@(posedge mclk) {aw, fav, fa} <= {w[0], 1'b1, v[15:0]};
			@(posedge mclk) fav <= 1'b0;
			mdl['h26] = w ? v[15:8] : 0;
			mdl['h27] = v[7:0];
			rdc('h26);
			rdc('h27);
		end
		n = 1 + ($unsigned($random(seed)) % 40);
		@(posedge mclk) rxw <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge mclk) tick <= 1'b1;
			@(posedge mclk) tick <= 1'b0;
		end
		@(posedge mclk) syn <= 1'b1;
		@(posedge mclk) {syn, rxw} <= 2'b00;
		mdl['h24] = 0;
		mdl['h25] = n;
		rdc('h24);
		rdc('h25);
		// The host owns turning the check off for empty payloads.
		// No payload passes through here, so any polynomial is legal.
		for (int a = 0; a < 64; a++) wrm(a, $random(seed));
		for (int a = 0; a < 64; a++) rdc(a);
		chk(cfg.frame_sync_pattern[31:16], {mdl['h32][7:0], mdl['h33][7:0]},
			"sync hi");
		chk(cfg.frame_sync_pattern[15:0], {mdl['h34][7:0], mdl['h35][7:0]},
			"sync lo");
		chk(cfg.check_polynomial, {mdl['h36][7:0], mdl['h37][7:0]},
			"poly");
		chk({6'h00, psym}, (mdl['h2F] + 7) * 2, "pre sym");
		chk({8'h00, cfg.preamble_length_setting}, mdl['h2F],
			"pre set");
		for (int m = 0; m < 4; m++) begin
			v = ($random(seed) & 'hC0) | (m << 2) | (3 - m);
			wrm('h2C, v);
			@(negedge mclk);
			chk({14'h0000, cfg.modulation_select}, m, "mod");
			chk({14'h0000, cfg.error_correction_rate}, 3 - m, "fec");
			chk({cfg.transmit_on_wake, cfg.auto_reply_enable}, v[7:6],
				"flags");
		end
		foreach (fl[f]) begin
			wrm('h2C, fl[f]);
			for (int k = 0; k < 3; k++) begin
				@(posedge mclk) {wake, rxs, txs} <= 3'b100 >> k;
				@(posedge mclk) {wake, rxs, txs} <= 3'b000;
				@(negedge mclk);
				v = (k == 0 && fl[f][7]) || (k == 1 && fl[f][6]);
				chk({txr, rxr}, {v[0], k == 2 && fl[f][6]},
					"auto");
			end
		end
		// Ticks are spaced so the end of the preamble is seen before the next.
		p = $unsigned($random(seed)) % 8;
		wrm('h2F, p);
		@(posedge mclk) pst <= 1'b1;
		@(posedge mclk) pst <= 1'b0;
		@(negedge mclk);
		chk({15'h0000, pact}, 16'h0001, "pre on");
		n = 0;
		while (pact === 1'b1 && n < 600) begin
			@(posedge mclk) tick <= 1'b1;
			@(posedge mclk) tick <= 1'b0;
			n++;
			@(posedge mclk);
			@(negedge mclk);
		end
		chk(n[15:0], (p + 7) * 2, "pre len");
		end_sim();
	end
endmodule // tb_top
